// ==== hdl/mfpc_pins.sv ====
// Operation
// - seven pins, output for status, input for control
// - per-pin function register, bit 7 direction
// - outputs keep old function until update
// - input pins: function write freezes controls
// - to input: select no-operation, update, then release
// - during reset drivers high-Z, straps latched after release
// - pins stay high-Z until EEPROM or software
// - straps choose EEPROM autoload and I2C/SPI
// - two straps give I2C address 0x48..0x4B
// - address straps only count at start-up
// - two-bit mode sets push-pull or open-drain
// - drive strength bit: 0 normal, 1 weak
// - mode fields packed into two registers
// - direction bit 0 makes pin a control input
// - OR-type terms first, then ANDed with rest
`timescale 1ns/1ps
module mfpc_pins
    import mfpc_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [6:0]   pin_in,
    output logic      [6:0]   pin_out,
    output logic      [6:0]   pin_oe,
    output logic      [6:0]   pin_weak,
    input  wire logic [127:0] status_src,
    input  wire logic         eeprom_busy,
    input  wire logic         eeprom_scl_low,
    input  wire logic         eeprom_sda_low,
    output logic      [127:0] ctrl_func,
    output logic              eeprom_autoload,
    output logic              serial_i2c,
    output logic      [6:0]   i2c_addr,
    output logic              startup_done
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        mfpc_boot_type       boot;
        logic [1:0]          settle;
        logic [6:0]          sync1;
        logic [6:0]          sync2;
        logic [6:0][7:0]     sh_func;
        logic [6:0][7:0]     act_func;
        logic [6:0][1:0]     sh_mode;
        logic [6:0][1:0]     act_mode;
        logic [6:0]          sh_weak;
        logic [6:0]          act_weak;
        logic                frozen;
        logic                upd_prev;
        logic [127:0]        ctrl;
        logic                load;
        logic                i2c;
        logic [6:0]          addr;
        logic                started;
        logic [6:0]          pin_out;
        logic [6:0]          pin_oe;
        logic [6:0]          pin_weak;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } mfpc_state_type;

    mfpc_state_type s;
    mfpc_state_type next_s;

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [9:0] reg_idx(input logic [11:0] a);
        reg_idx = a[11:2];
    endfunction

    function automatic logic reg_mapped(input logic [11:0] a);
        reg_mapped = (a[1:0] == 2'b00) && (reg_idx(a) >= IDX_MODE_LO)
                     && (reg_idx(a) <= IDX_PIN_LEVEL);
    endfunction

    // OR-type terms are gathered per function first; a function with no
    // OR-type pin sees a neutral 1 there so only its AND-type terms count
    function automatic logic [127:0] ctrl_eval(input logic [6:0][7:0] f,
                                               input logic [6:0][1:0] m,
                                               input logic [6:0]      lv);
        logic [127:0] or_v;
        logic [127:0] and_v;
        logic [127:0] has_or;
        logic [127:0] used;
        logic         t;
        or_v   = '0;
        and_v  = '1;
        has_or = '0;
        used   = '0;
        t      = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (!f[p][FUNC_DIR_BIT]) begin
                t = lv[p] ^ m[p][0];
                used[f[p][6:0]] = 1'b1;
                if (m[p][1]) begin
                    has_or[f[p][6:0]] = 1'b1;
                    or_v[f[p][6:0]]   = or_v[f[p][6:0]] | t;
                end else begin
                    and_v[f[p][6:0]]  = and_v[f[p][6:0]] & t;
                end
            end
        end
        ctrl_eval = used & and_v & (or_v | ~has_or);
        ctrl_eval[CODE_NO_OPERATION_FUNCTION] = 1'b0;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic       access;
    logic       done;
    logic       wr;
    logic [9:0] idx;
    logic       upd;
    logic       any_input;
    logic       wr_func;
    logic       a;
    logic [31:0] rd;

    always_comb begin
        next_s    = s;
        access    = psel && penable;
        done      = access && s.pready;
        wr        = done && pwrite && reg_mapped(paddr);
        idx       = reg_idx(paddr);
        any_input = 1'b0;
        a         = 1'b0;
        rd        = '0;
        for (int p = 0; p < NUM_PINS; p++) begin
            any_input = any_input || !s.act_func[p][FUNC_DIR_BIT];
        end
        wr_func = wr && (idx >= IDX_FUNC_FIRST) && (idx <= IDX_FUNC_LAST);
        // software strobe or a pin-driven update, taken on its rising edge
        upd = (wr && (idx == IDX_UPDATE) && pwdata[UPDATE_BIT])
              || (s.ctrl[CODE_IO_UPDATE] && !s.upd_prev);

        // first stage feeds only the second
        next_s.sync1    = pin_in;
        next_s.sync2    = s.sync1;
        next_s.upd_prev = s.ctrl[CODE_IO_UPDATE];

        // start-up: straps read once through the synchroniser, then held
        unique case (s.boot)
            BOOT_SETTLE: begin
                next_s.settle = s.settle + 2'h1;
                if (s.settle == STRAP_SETTLE) begin
                    next_s.boot = BOOT_LATCH;
                end
            end
            BOOT_LATCH: begin
                next_s.load = s.sync2[PIN_EEPROM];
                next_s.i2c  = s.sync2[PIN_SERIAL];
                next_s.addr = s.sync2[PIN_SERIAL]
                              ? (I2C_ADDR_BASE | {5'h00, s.sync2[PIN_ADDR_HI],
                                                 s.sync2[PIN_ADDR_LO]})
                              : 7'h00;
                next_s.started = 1'b1;
                next_s.boot = BOOT_RUN;
            end
            BOOT_RUN: begin
                next_s.boot = BOOT_RUN;
            end
            default: begin
                next_s.boot = BOOT_SETTLE;
            end
        endcase

        // register writes land in shadow storage only
        if (wr) begin
            if (idx == IDX_MODE_LO) begin
                for (int p = 0; p < PINS_PER_MODE; p++) begin
                    next_s.sh_mode[p] = pwdata[2*p +: 2];
                end
            end
            if (idx == IDX_MODE_HI) begin
                for (int p = PINS_PER_MODE; p < NUM_PINS; p++) begin
                    next_s.sh_mode[p] = pwdata[2*(p-PINS_PER_MODE) +: 2];
                end
            end
            if (wr_func) begin
                next_s.sh_func[idx - IDX_FUNC_FIRST] = pwdata[7:0];
            end
            if (idx == IDX_STRENGTH) begin
                next_s.sh_weak = pwdata[6:0];
            end
        end

        // commit and control tracking
        if (upd) begin
            next_s.act_func = next_s.sh_func;
            next_s.act_mode = next_s.sh_mode;
            next_s.act_weak = next_s.sh_weak;
            next_s.frozen   = 1'b0;
        end else if (wr_func && any_input) begin
            next_s.frozen   = 1'b1;
        end
        if (!s.frozen && !(wr_func && any_input)) begin
            next_s.ctrl = ctrl_eval(s.act_func, s.act_mode, s.sync2);
        end

        // pin drivers, computed whole and registered once per pin
        for (int p = 0; p < NUM_PINS; p++) begin
            next_s.pin_out[p]  = 1'b0;
            next_s.pin_oe[p]   = 1'b0;
            next_s.pin_weak[p] = 1'b0;
            if (s.boot != BOOT_RUN) begin
                next_s.pin_oe[p] = 1'b0;
            end else if (eeprom_busy && (p == PIN_I2C_SCL)) begin
                next_s.pin_oe[p] = eeprom_scl_low;
            end else if (eeprom_busy && (p == PIN_I2C_SDA)) begin
                next_s.pin_oe[p] = eeprom_sda_low;
            end else if (s.act_func[p][FUNC_DIR_BIT]) begin
                a = status_src[s.act_func[p][6:0]];
                next_s.pin_weak[p] = s.act_weak[p];
                unique case (mfpc_mode_type'(s.act_mode[p]))
                    MODE_PP_HIGH: begin
                        next_s.pin_oe[p]  = 1'b1;
                        next_s.pin_out[p] = a;
                    end
                    MODE_PP_LOW: begin
                        next_s.pin_oe[p]  = 1'b1;
                        next_s.pin_out[p] = !a;
                    end
                    MODE_OD_HIGH: begin
                        next_s.pin_oe[p]  = a;
                        next_s.pin_out[p] = 1'b1;
                    end
                    MODE_OD_LOW: begin
                        next_s.pin_oe[p]  = a;
                        next_s.pin_out[p] = 1'b0;
                    end
                endcase
            end
        end

        // apb: one wait state, answer computed at the first access cycle
        next_s.pready = access && !s.pready;
        if (access && !s.pready) begin
            unique case (idx)
                IDX_MODE_LO: begin
                    rd[7:0] = {s.sh_mode[3], s.sh_mode[2], s.sh_mode[1], s.sh_mode[0]};
                end
                IDX_MODE_HI: begin
                    rd[5:0] = {s.sh_mode[6], s.sh_mode[5], s.sh_mode[4]};
                end
                IDX_STRENGTH: begin
                    rd[6:0] = s.sh_weak;
                end
                IDX_STRAP: begin
                    rd[STRAP_LOAD_BIT] = s.load;
                    rd[STRAP_I2C_BIT]  = s.i2c;
                    rd[STRAP_DONE_BIT] = (s.boot == BOOT_RUN);
                    rd[STRAP_FRZ_BIT]  = s.frozen;
                    rd[STRAP_ADDR_LSB +: 7] = s.addr;
                end
                IDX_PIN_LEVEL: begin
                    rd[6:0] = s.sync2;
                    rd[LEVEL_OE_LSB +: 7] = s.pin_oe;
                end
                default: begin
                    if (idx >= IDX_FUNC_FIRST && idx <= IDX_FUNC_LAST) begin
                        rd[7:0] = s.sh_func[idx - IDX_FUNC_FIRST];
                    end
                end
            endcase
            next_s.prdata  = (pwrite || !reg_mapped(paddr)) ? 32'h0000_0000 : rd;
            next_s.pslverr = !reg_mapped(paddr);
        end else if (done) begin
            next_s.prdata  = 32'h0000_0000;
            next_s.pslverr = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; all reset values are zero (function, mode, strength)

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata          = s.prdata;
    assign pready          = s.pready;
    assign pslverr         = s.pslverr;
    assign pin_out         = s.pin_out;
    assign pin_oe          = s.pin_oe;
    assign pin_weak        = s.pin_weak;
    assign ctrl_func       = s.ctrl;
    assign eeprom_autoload = s.load;
    assign serial_i2c      = s.i2c;
    assign i2c_addr        = s.addr;
    assign startup_done    = s.started;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence pin0_pp_high;
        s.boot == BOOT_RUN && s.act_func[0][FUNC_DIR_BIT]
            && s.act_mode[0] == MODE_PP_HIGH;
    endsequence

    sequence pin0_input;
        s.boot == BOOT_RUN && !s.act_func[0][FUNC_DIR_BIT];
    endsequence

    chk_boot_hiz_drv: assert property (
        (s.boot != BOOT_RUN) |=> (pin_oe == 7'h00))
        else $error("pin driven before start-up finished");

    chk_strap_held: assert property (
        (s.boot == BOOT_RUN) |=> $stable(i2c_addr) && $stable(serial_i2c))
        else $error("strap result changed after start-up");

    chk_addr_range: assert property (
        (s.boot == BOOT_RUN && serial_i2c) |-> (i2c_addr[6:2] == 5'h12))
        else $error("i2c address outside 0x48..0x4b");

    chk_act_hold: assert property (
        !upd |=> $stable(s.act_func) && $stable(s.act_mode))
        else $error("active setting changed without update");

    chk_commit_all: assert property (
        (upd && !(wr && idx != IDX_UPDATE)) |=> (s.act_func == $past(s.sh_func))
                         && (s.act_mode == $past(s.sh_mode))
                         && (s.act_weak == $past(s.sh_weak)))
        else $error("update did not commit shadow settings");

    chk_freeze_hold: assert property (
        (s.frozen && !upd) |=> $stable(ctrl_func))
        else $error("control outputs moved while frozen");

    chk_status_drive: assert property (
        (pin0_pp_high ##0 !eeprom_busy) |=>
            pin_oe[0] && pin_out[0] == $past(status_src[s.act_func[0][6:0]]))
        else $error("push-pull status pin not following source");

    chk_input_release: assert property (
        pin0_input |=> !pin_oe[0])
        else $error("input pin still driven");

    chk_weak_outputs: assert property (
        pin_weak[0] |-> $past(s.act_func[0][FUNC_DIR_BIT] && s.act_weak[0]))
        else $error("weak drive on a non-status pin");

    chk_apb_wait: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one wait state");

endmodule

// ==== hdl/mfpc_pkg.sv ====
package mfpc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int         NUM_PINS       = 7;
    localparam int         NUM_CODES      = 128;

    ////////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_MODE_LO    = 10'h100;
    localparam logic [9:0] IDX_MODE_HI    = 10'h101;
    localparam logic [9:0] IDX_FUNC_FIRST = 10'h102;
    localparam logic [9:0] IDX_FUNC_LAST  = 10'h108;
    localparam logic [9:0] IDX_STRENGTH   = 10'h109;
    localparam logic [9:0] IDX_UPDATE     = 10'h10a;
    localparam logic [9:0] IDX_STRAP      = 10'h10b;
    localparam logic [9:0] IDX_PIN_LEVEL  = 10'h10c;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int         FUNC_DIR_BIT   = 7;
    localparam int         UPDATE_BIT     = 0;
    localparam int         PINS_PER_MODE  = 4;
    localparam int         STRAP_LOAD_BIT = 0;
    localparam int         STRAP_I2C_BIT  = 1;
    localparam int         STRAP_DONE_BIT = 2;
    localparam int         STRAP_FRZ_BIT  = 3;
    localparam int         STRAP_ADDR_LSB = 8;
    localparam int         LEVEL_OE_LSB   = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] FUNC_RESET     = 8'h00;
    localparam logic [1:0] MODE_RESET     = 2'h0;
    localparam logic       WEAK_RESET     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // strap pins and codes
    localparam int         PIN_EEPROM     = 3;
    localparam int         PIN_SERIAL     = 4;
    localparam int         PIN_ADDR_LO    = 5;
    localparam int         PIN_ADDR_HI    = 6;
    localparam int         PIN_I2C_SCL    = 1;
    localparam int         PIN_I2C_SDA    = 2;
    localparam logic [6:0] I2C_ADDR_BASE  = 7'h48;
    localparam logic [6:0] CODE_NO_OPERATION_FUNCTION      = 7'h00;
    localparam logic [6:0] CODE_IO_UPDATE = 7'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // timing: synchroniser depth before straps are trusted
    localparam logic [1:0] STRAP_SETTLE   = 2'h2;

    typedef enum logic [1:0] {
        MODE_PP_HIGH = 2'b00,
        MODE_PP_LOW  = 2'b01,
        MODE_OD_HIGH = 2'b10,
        MODE_OD_LOW  = 2'b11
    } mfpc_mode_type;

    typedef enum logic [1:0] {
        BOOT_SETTLE = 2'b00,
        BOOT_LATCH  = 2'b01,
        BOOT_RUN    = 2'b10
    } mfpc_boot_type;

endpackage

// ==== bench/mfpc_board.sv ====
`timescale 1ns/1ps
module mfpc_board (
    input  wire logic       ref_clk,
    input  wire logic [6:0] dev_oe,
    input  wire logic [6:0] dev_out,
    input  wire logic [6:0] ext_en,
    input  wire logic [6:0] ext_val,
    output logic      [6:0] level
);
    ////////////////////////////////////////
    // a floating line other than pins 3 and 4 must never look like a firm level, so it toggles
    logic [6:0] flt = 7'h55;

    always_ff @(posedge ref_clk) begin
        flt <= ~flt;
    end

    always_comb begin
        for (int p = 0; p < 7; p++) begin
            if (dev_oe[p]) begin
                level[p] = dev_out[p];
            end else if (ext_en[p]) begin
                level[p] = ext_val[p];
            end else if (p == 3 || p == 4) begin
                level[p] = 1'b0; // internal pull-down on the EEPROM and serial strap pins
            end else begin
                level[p] = flt[p];
            end
        end
    end
endmodule

// ==== bench/mfpc_pins_test.sv ====
`timescale 1ns/1ps
module mfpc_pins_test
    import mfpc_pkg::*;
();
    logic         ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [6:0]   pin_in, pin_out, pin_oe, pin_weak, ext_en, ext_val, i2c_addr;
    logic [127:0] status_src, ctrl_func;
    logic         eeprom_busy, eeprom_scl_low, eeprom_sda_low;
    logic         eeprom_autoload, serial_i2c, startup_done;
    int           n_errors, tests_run;

    mfpc_pins i_dut (.ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_weak, .status_src,
        .eeprom_busy, .eeprom_scl_low, .eeprom_sda_low, .ctrl_func, .eeprom_autoload,
        .serial_i2c, .i2c_addr, .startup_done);
    mfpc_board i_board (.ref_clk, .dev_oe(pin_oe), .dev_out(pin_out), .ext_en, .ext_val,
        .level(pin_in));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            check("apb pready", 0, 1);
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset;
        int n;
        resetn <= 1'b0;
        tick(12);
        check("oe in reset", 32'(pin_oe), 0);
        resetn <= 1'b1;
        n = 0;
        while (startup_done !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (n >= 20) begin
            check("startup", 0, 1);
            complete_run();
        end
        tick(1);
    endtask

    ////////////////////////////////////////
    task automatic test_straps;
        for (int a = 0; a < 4; a++) begin
            ext_val <= {2'(a), 5'b11000};
            do_reset();
            check("i2c addr", 32'(i2c_addr), 32'h48 + a);
            check("i2c mode", 32'(serial_i2c), 1);
            check("autoload", 32'(eeprom_autoload), 1);
        end
        ext_val <= 7'h18;
        tick(8);
        check("addr held", 32'(i2c_addr), 32'h4b);
        ext_en <= 7'h00;
        do_reset();
        check("spi mode", 32'(serial_i2c), 0);
        check("no autoload", 32'(eeprom_autoload), 0);
        check("spi addr", 32'(i2c_addr), 0);
        check("oe idle", 32'(pin_oe), 0);
        apb(1'b0, IDX_STRAP, 0);
        check("strap reg", rd, 32'h1 << STRAP_DONE_BIT);
    endtask

    task automatic test_regs;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, IDX_MODE_LO + 10'(i), 0);
            check("reg reset", rd, 0);
        end
        apb(1'b1, IDX_FUNC_FIRST + 10'h3, 32'hffff_ffa5);
        apb(1'b0, IDX_FUNC_FIRST + 10'h3, 0);
        check("func readback", rd, 32'ha5);
        apb(1'b0, 10'h0ff, 0);
        check("unmapped err", 32'(err), 1);
        apb(1'b1, IDX_FUNC_FIRST + 10'h3, 0);
        apb(1'b1, IDX_UPDATE, 1);
    endtask

    task automatic test_control;
        int pins[4] = '{2, 3, 4, 6};
        ext_en <= 7'h5c;
        apb(1'b1, IDX_MODE_LO, 32'hc0);
        apb(1'b1, IDX_MODE_HI, 32'h21);
        foreach (pins[i]) apb(1'b1, IDX_FUNC_FIRST + 10'(pins[i]), 32'h21);
        apb(1'b1, IDX_UPDATE, 1);
        for (int k = 0; k < 16; k++) begin
            ext_val <= {k[3], 1'b0, k[2], k[1], k[0], 2'b00};
            tick(5);
            check("ctrl combine", 32'(ctrl_func[33]), 32'((~k[1] | k[3]) & k[0] & ~k[2]));
        end
        ext_val <= 7'h04;
        tick(5);
        apb(1'b1, IDX_FUNC_FIRST + 10'h5, 0);
        ext_val <= 7'h00;
        tick(5);
        check("ctrl frozen", 32'(ctrl_func[33]), 1);
        apb(1'b1, IDX_UPDATE, 1);
        tick(5);
        check("ctrl resumed", 32'(ctrl_func[33]), 0);
    endtask

    task automatic test_status;
        logic e;
        apb(1'b1, IDX_FUNC_FIRST, 32'h85);
        apb(1'b1, IDX_STRENGTH, 1);
        tick(3);
        check("oe before update", 32'(pin_oe[0]), 0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, IDX_MODE_LO, 32'hc0 | m);
            apb(1'b1, IDX_UPDATE, 1);
            for (int s = 0; s < 2; s++) begin
                status_src[5] <= s[0];
                tick(4);
                e = (m < 2) | s[0];
                check("status oe", 32'(pin_oe[0]), 32'(e));
                if (e) check("status out", 32'(pin_out[0]), 32'(s[0] ^ m[0]));
            end
        end
        check("weak drive", 32'(pin_weak[0]), 1);
        apb(1'b1, IDX_MODE_LO, 32'hc0);
        apb(1'b1, IDX_UPDATE, 1);
        status_src[5] <= 1'b1;
        apb(1'b1, IDX_FUNC_FIRST, 32'h86);
        tick(4);
        check("old function", 32'(pin_out[0]), 1);
        apb(1'b1, IDX_UPDATE, 1);
        for (int c = 0; c < 6; c++) begin
            tick(1);
            check("oe steady", 32'(pin_oe[0]), 1);
        end
        check("new function", 32'(pin_out[0]), 0);
        // back to input via no-operation first, avoiding a fight on the pin
        apb(1'b1, IDX_FUNC_FIRST, 32'h00);
        tick(4);
        check("held until update", 32'(pin_oe[0]), 1);
        apb(1'b1, IDX_UPDATE, 1);
        tick(3);
        check("released", 32'(pin_oe[0]), 0);
    endtask

    task automatic test_eeprom;
        eeprom_busy <= 1'b1;
        eeprom_scl_low <= 1'b1;
        tick(3);
        check("scl oe", 32'(pin_oe[1]), 1);
        check("scl out", 32'(pin_out[1]), 0);
        check("sda oe", 32'(pin_oe[2]), 0);
        eeprom_scl_low <= 1'b0;
        eeprom_sda_low <= 1'b1;
        tick(3);
        check("scl free", 32'(pin_oe[1]), 0);
        check("sda pulled", 32'(pin_oe[2]), 1);
        check("sda out", 32'(pin_out[2]), 0);
        eeprom_busy <= 1'b0;
        eeprom_sda_low <= 1'b0;
        tick(3);
        check("bus released", 32'(pin_oe[2:1]), 0);
    endtask

    task automatic test_pin_update;
        ext_val <= 7'h00;
        apb(1'b1, IDX_FUNC_FIRST + 10'h2, 32'(CODE_IO_UPDATE));
        apb(1'b1, IDX_FUNC_FIRST, 32'h80);
        apb(1'b1, IDX_UPDATE, 1);
        tick(4);
        check("src0 driven", 32'(pin_oe[0]), 1);
        check("src0 level", 32'(pin_out[0]), 0);
        apb(1'b1, IDX_MODE_LO, 32'hc1);
        tick(6);
        check("mode staged", 32'(pin_out[0]), 0);
        ext_val <= 7'h04;
        tick(8);
        check("pin update", 32'(pin_out[0]), 1);
    endtask

    ////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        status_src = '0;
        eeprom_busy = 1'b0;
        eeprom_scl_low = 1'b0;
        eeprom_sda_low = 1'b0;
        ext_en = 7'h78;
        ext_val = 7'h18;
        n_errors = 0;
        tests_run = 0;
        test_straps();
        test_regs();
        test_control();
        test_status();
        test_eeprom();
        test_pin_update();
        complete_run();
    end
endmodule
